//--- rtl/dmdc_diag_enc.sv
// Purpose: fault number to diagnosis channel codes
// Assumes: main index 8 bits, subindex 4 bits
// Notes:   alarm is raise delayed one cycle, with codes held
`timescale 1ns/10ps
`default_nettype none
module dmdc_diag_enc (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // fault event
  input  wire logic        raise,
  input  wire logic [7:0]  mainIdx,
  input  wire logic [3:0]  subIdx,
  // alarm out
  output logic             alarm,
  output logic [15:0]      chanErr,
  output logic [15:0]      extErr
);
  logic        alarm_q, alarm_d;
  logic [15:0] chan_q, chan_d, ext_q, ext_d;

  always_comb begin
    alarm_d = raise;
    chan_d  = chan_q;
    ext_d   = ext_q;
    if (raise) begin
      chan_d = dmdc_pkg::CHAN_ERR_BASE + {8'h00, mainIdx};
      ext_d  = dmdc_pkg::EXT_ERR_BASE + {12'h000, subIdx};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_q <= 1'b0;
      chan_q  <= '0;
      ext_q   <= '0;
    end else begin
      alarm_q <= alarm_d;
      chan_q  <= chan_d;
      ext_q   <= ext_d;
    end
  end

  assign alarm   = alarm_q;
  assign chanErr = chan_q;
  assign extErr  = ext_q;

  chk_chan_code: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    raise |=> alarm_q && chan_q == 16'h1000 + $past(mainIdx)
      && chan_q <= dmdc_pkg::CHAN_ERR_MAX)
    else $error("channel code wrong");
  chk_ext_code: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    raise |=> ext_q == 16'h1000 + $past(subIdx)
      && ext_q <= dmdc_pkg::EXT_ERR_MAX)
    else $error("extended code wrong");
endmodule // dmdc_diag_enc
`default_nettype wire

//--- rtl/dmdc_pkg.sv
// Purpose: shared constants for drive mode and diagnosis control
// Assumes: 250 MHz sys_clk, AHB-Lite register access
// Notes:   byte offsets, field positions, reset values, timings
package dmdc_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned MODE_SWITCH_NS  = 1000;
  localparam int unsigned MODE_SWITCH_CYC =
    (MODE_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_RXTEL  = 8'h00;
  localparam logic [7:0] OFS_OPMODE = 8'h04;
  localparam logic [7:0] OFS_SETPT  = 8'h08;
  localparam logic [7:0] OFS_RAMP   = 8'h0C;
  localparam logic [7:0] OFS_VEL    = 8'h10;
  localparam logic [7:0] OFS_ACC    = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  localparam logic [7:0] OFS_HOMING = 8'h1C;
  localparam logic [7:0] OFS_FAULT  = 8'h20;
  localparam logic [7:0] OFS_DIAG   = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  //////////////////////////////////////////////////////////////////////////
  // telegram register fields
  localparam int unsigned RX_CW_LSB    = 0;
  localparam int unsigned RX_TEL_LSB   = 16;
  localparam int unsigned RX_COMMS_BIT = 18;
  localparam int unsigned RX_IDENT_LSB = 24;
  localparam logic [7:0]  TEL_IDENT    = 8'hE0;
  localparam logic [1:0]  TEL_POS      = 2'h0;
  localparam logic [1:0]  TEL_SPEED    = 2'h1;
  // control word 1 bits
  localparam int unsigned CW_RAMP_RUN = 5;
  localparam int unsigned CW_SP_EN    = 6;
  localparam int unsigned CW_START    = 6;
  localparam int unsigned CW_HOME     = 11;
  localparam int unsigned CW_REL      = 12;
  localparam int unsigned CW_CHG_NOW  = 13;
  // fault register fields
  localparam int unsigned FLT_SUB_LSB = 8;
  localparam int unsigned FLT_RAISE   = 12;
  // diagnosis code ranges
  localparam logic [15:0] CHAN_ERR_BASE = 16'h1000;
  localparam logic [15:0] CHAN_ERR_MAX  = 16'h7FFF;
  localparam logic [15:0] EXT_ERR_BASE  = 16'h1000;
  localparam logic [15:0] EXT_ERR_MAX   = 16'h100F;
  // reset values
  localparam logic [15:0] STEP_RST   = 16'h0001;
  localparam logic [7:0]  HOMING_RST = 8'h00;
  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    MODE_TORQUE = 2'h0,
    MODE_SPEED  = 2'h1,
    MODE_POS    = 2'h2
  } dmdc_mode_e;
  typedef enum logic [1:0] {
    TASK_IDLE   = 2'h0,
    TASK_RUN    = 2'h1,
    TASK_QUEUED = 2'h3
  } dmdc_task_e;
endpackage

//--- rtl/dmdc_ramp.sv
// Purpose: rate limiting setpoint ramp with freeze
// Assumes: signed setpoints, unsigned step per clock
// Notes:   output held while hold is high
`timescale 1ns/10ps
`default_nettype none
module dmdc_ramp #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // control
  input  wire logic signed [W-1:0] target,
  input  wire logic        [W-1:0] step,
  input  wire logic                hold,
  // result
  output logic signed      [W-1:0] rampOut
);
  logic signed [W-1:0] out_q;
  logic signed [W-1:0] out_d;
  logic signed [W:0]   diff;

  always_comb begin
    diff  = {target[W-1], target} - {out_q[W-1], out_q};
    out_d = out_q;
    if (!hold) begin
      if (diff > $signed({1'b0, step})) begin
        out_d = W'(out_q + $signed(step));
      end else if (diff < -$signed({1'b0, step})) begin
        out_d = W'(out_q - $signed(step));
      end else begin
        out_d = target;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign rampOut = out_q;

  chk_ramp_frozen: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    hold |=> out_q == $past(out_q))
    else $error("ramp moved while frozen");
endmodule // dmdc_ramp
`default_nettype wire

//--- rtl/dmdc_top.sv
// Purpose: drive mode selection, setpoint path, positioning tasks, alarms
// Assumes: telegrams and faults delivered by register writes
// Notes:   AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/10ps
`default_nettype none
module dmdc_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // motion engine
  input  wire logic        taskDone,
  output logic             taskStart,
  output logic             taskAbort,
  output logic [31:0]      taskTarget,
  output logic             taskRelative,
  output logic             taskBlend,
  output logic [15:0]      taskProfVel,
  output logic [15:0]      taskEndVel,
  output logic [15:0]      taskAcc,
  output logic [15:0]      taskDec,
  output logic             homingStart,
  output logic [7:0]       homingMethod,
  // setpoint path
  output logic [1:0]       modeActive,
  output logic             selFix1,
  output logic [15:0]      setpointOut,
  // diagnosis alarm
  output logic             diagAlarm,
  output logic [15:0]      chanErrType,
  output logic [15:0]      extChanErrType
);
  localparam int unsigned CW = $clog2(dmdc_pkg::MODE_SWITCH_CYC + 1);
  localparam logic [CW-1:0] SW_LAST = CW'(dmdc_pkg::MODE_SWITCH_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic        dpSel_q, dpSel_d, dpWr_q, dpWr_d;
  logic [7:0]  dpAddr_q, dpAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] cw1_q, cw1_d;
  logic [1:0]  telNum_q, telNum_d;
  logic        comms_q, comms_d;
  logic [1:0]  modeParam_q, modeParam_d, modeReq_q, modeReq_d;
  logic [1:0]  modeAct_q, modeAct_d;
  logic [CW-1:0] swCnt_q, swCnt_d;
  logic [15:0] setpt_q, setpt_d, step_q, step_d;
  logic [15:0] prof_q, prof_d, endv_q, endv_d, acc_q, acc_d, dec_q, dec_d;
  logic [31:0] target_q, target_d;
  logic [7:0]  homeMeth_q, homeMeth_d, fltMain_q, fltMain_d;
  logic [3:0]  fltSub_q, fltSub_d;
  logic        raise_q, raise_d;
  dmdc_pkg::dmdc_task_e task_q, task_d;
  logic [31:0] qTgt_q, qTgt_d, tTgt_q, tTgt_d;
  logic        qRel_q, qRel_d, tRel_q, tRel_d, qBlend_q, qBlend_d;
  logic        tBlend_q, tBlend_d;
  logic [15:0] qProf_q, qProf_d, qEnd_q, qEnd_d, tProf_q, tProf_d;
  logic [15:0] tEnd_q, tEnd_d;
  logic        start_q, start_d, abort_q, abort_d, home_q, home_d;
  // decode
  logic        apValid, wrStb, telStb, startEdge, homeEdge;
  logic [15:0] newCw;
  logic [15:0] rampTarget, rampOut;
  logic        rampHold, fix1;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and telegram intake
  always_comb begin
    apValid = hsel && htrans[1] && hready;
    wrStb   = dpSel_q && dpWr_q;
    newCw   = hwdata[dmdc_pkg::RX_CW_LSB +: 16];
    telStb  = wrStb && dpAddr_q == dmdc_pkg::OFS_RXTEL
      && hwdata[dmdc_pkg::RX_IDENT_LSB +: 8] == dmdc_pkg::TEL_IDENT;
    startEdge = telStb && newCw[dmdc_pkg::CW_START]
      && !cw1_q[dmdc_pkg::CW_START];
    homeEdge  = telStb && newCw[dmdc_pkg::CW_HOME]
      && !cw1_q[dmdc_pkg::CW_HOME];
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint selector
  always_comb begin
    // fixed setpoint 1 in speed mode
    fix1 = modeAct_q == dmdc_pkg::MODE_SPEED && comms_q
      && cw1_q[dmdc_pkg::CW_SP_EN];
    rampHold = modeAct_q == dmdc_pkg::MODE_SPEED
      && !cw1_q[dmdc_pkg::CW_RAMP_RUN];
    if (modeAct_q == dmdc_pkg::MODE_TORQUE || fix1) begin
      rampTarget = setpt_q;
    end else begin
      rampTarget = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    dpSel_d = apValid;
    dpWr_d = apValid && hwrite;
    dpAddr_d = apValid ? haddr : dpAddr_q;
    cw1_d = cw1_q; telNum_d = telNum_q; comms_d = comms_q;
    modeParam_d = modeParam_q; modeReq_d = modeReq_q;
    modeAct_d = modeAct_q; swCnt_d = swCnt_q;
    setpt_d = setpt_q; step_d = step_q; prof_d = prof_q;
    endv_d = endv_q; acc_d = acc_q; dec_d = dec_q;
    target_d = target_q; homeMeth_d = homeMeth_q;
    fltMain_d = fltMain_q; fltSub_d = fltSub_q; raise_d = 1'b0;
    task_d = task_q; qTgt_d = qTgt_q; qRel_d = qRel_q;
    qBlend_d = qBlend_q; qProf_d = qProf_q; qEnd_d = qEnd_q;
    tTgt_d = tTgt_q; tRel_d = tRel_q; tBlend_d = tBlend_q;
    tProf_d = tProf_q; tEnd_d = tEnd_q;
    start_d = 1'b0; abort_d = 1'b0; home_d = 1'b0;
    if (wrStb) begin
      unique case (dpAddr_q)
        dmdc_pkg::OFS_OPMODE: begin
          modeParam_d = hwdata[1:0];
          if (telNum_q[1]) begin
            modeReq_d = hwdata[1:0];
          end
        end
        dmdc_pkg::OFS_SETPT: begin
          setpt_d = hwdata[15:0];
          step_d = hwdata[31:16];
        end
        dmdc_pkg::OFS_VEL: begin
          prof_d = hwdata[15:0];
          endv_d = hwdata[31:16];
        end
        dmdc_pkg::OFS_ACC: begin
          acc_d = hwdata[15:0];
          dec_d = hwdata[31:16];
        end
        dmdc_pkg::OFS_TARGET: target_d = hwdata;
        dmdc_pkg::OFS_HOMING: homeMeth_d = hwdata[7:0];
        dmdc_pkg::OFS_FAULT: begin
          fltMain_d = hwdata[7:0];
          fltSub_d = hwdata[dmdc_pkg::FLT_SUB_LSB +: 4];
          raise_d = hwdata[dmdc_pkg::FLT_RAISE];
        end
        default: ;
      endcase
    end
    if (telStb) begin
      cw1_d = newCw;
      telNum_d = hwdata[dmdc_pkg::RX_TEL_LSB +: 2];
      comms_d = hwdata[dmdc_pkg::RX_COMMS_BIT];
      if (telNum_d == dmdc_pkg::TEL_POS) begin
        modeReq_d = dmdc_pkg::MODE_POS;
      end else if (telNum_d == dmdc_pkg::TEL_SPEED) begin
        modeReq_d = dmdc_pkg::MODE_SPEED;
      end else begin
        modeReq_d = modeParam_q;
      end
    end
    if (modeReq_q == modeAct_q) begin
      swCnt_d = '0;
    end else if (swCnt_q == SW_LAST) begin
      modeAct_d = modeReq_q;
      swCnt_d = '0;
    end else begin
      swCnt_d = swCnt_q + 1'b1;
    end
    if (homeEdge && modeAct_q == dmdc_pkg::MODE_POS) begin
      home_d = 1'b1;
    end
    if (startEdge && modeAct_q == dmdc_pkg::MODE_POS) begin
      if (task_q == dmdc_pkg::TASK_IDLE
          || newCw[dmdc_pkg::CW_CHG_NOW]) begin
        abort_d = task_q != dmdc_pkg::TASK_IDLE;
        start_d = 1'b1;
        task_d = dmdc_pkg::TASK_RUN;
        tTgt_d = target_q;
        tRel_d = newCw[dmdc_pkg::CW_REL];
        tBlend_d = 1'b0;
        tProf_d = prof_q;
        tEnd_d = endv_q;
      end else begin
        task_d = dmdc_pkg::TASK_QUEUED;
        qTgt_d = target_q;
        qRel_d = newCw[dmdc_pkg::CW_REL];
        qProf_d = prof_q;
        qEnd_d = endv_q;
        qBlend_d = tEnd_q == prof_q;
      end
    end else if (taskDone) begin
      unique case (task_q)
        dmdc_pkg::TASK_RUN: task_d = dmdc_pkg::TASK_IDLE;
        dmdc_pkg::TASK_QUEUED: begin
          task_d = dmdc_pkg::TASK_RUN;
          start_d = 1'b1;
          tTgt_d = qTgt_q;
          tRel_d = qRel_q;
          tBlend_d = qBlend_q;
          tProf_d = qProf_q;
          tEnd_d = qEnd_q;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered in the address phase
  always_comb begin
    rdata_d = '0;
    if (apValid && !hwrite) begin
      unique case (haddr)
        dmdc_pkg::OFS_RXTEL: rdata_d = {14'h0000, telNum_q, cw1_q};
        dmdc_pkg::OFS_OPMODE:
          rdata_d = {27'h0000000, swCnt_q != '0, modeParam_q, modeAct_q};
        dmdc_pkg::OFS_SETPT: rdata_d = {step_q, setpt_q};
        dmdc_pkg::OFS_RAMP: rdata_d = {16'h0000, rampOut};
        dmdc_pkg::OFS_VEL: rdata_d = {endv_q, prof_q};
        dmdc_pkg::OFS_ACC: rdata_d = {dec_q, acc_q};
        dmdc_pkg::OFS_TARGET: rdata_d = target_q;
        dmdc_pkg::OFS_HOMING: rdata_d = {24'h000000, homeMeth_q};
        dmdc_pkg::OFS_FAULT: rdata_d = {20'h00000, fltSub_q, fltMain_q};
        dmdc_pkg::OFS_DIAG: rdata_d = {extChanErrType, chanErrType};
        dmdc_pkg::OFS_STATUS:
          rdata_d = {27'h0000000, fix1, tBlend_q, tRel_q, task_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dpSel_q <= 1'b0; dpWr_q <= 1'b0; dpAddr_q <= '0; rdata_q <= '0;
      cw1_q <= '0; telNum_q <= '0; comms_q <= 1'b0;
      modeParam_q <= dmdc_pkg::MODE_TORQUE;
      modeReq_q <= dmdc_pkg::MODE_TORQUE;
      modeAct_q <= dmdc_pkg::MODE_TORQUE;
      swCnt_q <= '0; setpt_q <= '0; step_q <= dmdc_pkg::STEP_RST;
      prof_q <= '0; endv_q <= '0; acc_q <= '0; dec_q <= '0;
      target_q <= '0; homeMeth_q <= dmdc_pkg::HOMING_RST;
      fltMain_q <= '0; fltSub_q <= '0; raise_q <= 1'b0;
      task_q <= dmdc_pkg::TASK_IDLE;
      qTgt_q <= '0; qRel_q <= 1'b0; qBlend_q <= 1'b0;
      qProf_q <= '0; qEnd_q <= '0;
      tTgt_q <= '0; tRel_q <= 1'b0; tBlend_q <= 1'b0;
      tProf_q <= '0; tEnd_q <= '0;
      start_q <= 1'b0; abort_q <= 1'b0; home_q <= 1'b0;
    end else begin
      dpSel_q <= dpSel_d; dpWr_q <= dpWr_d; dpAddr_q <= dpAddr_d;
      rdata_q <= rdata_d;
      cw1_q <= cw1_d; telNum_q <= telNum_d; comms_q <= comms_d;
      modeParam_q <= modeParam_d; modeReq_q <= modeReq_d;
      modeAct_q <= modeAct_d; swCnt_q <= swCnt_d;
      setpt_q <= setpt_d; step_q <= step_d;
      prof_q <= prof_d; endv_q <= endv_d; acc_q <= acc_d; dec_q <= dec_d;
      target_q <= target_d; homeMeth_q <= homeMeth_d;
      fltMain_q <= fltMain_d; fltSub_q <= fltSub_d; raise_q <= raise_d;
      task_q <= task_d;
      qTgt_q <= qTgt_d; qRel_q <= qRel_d; qBlend_q <= qBlend_d;
      qProf_q <= qProf_d; qEnd_q <= qEnd_d;
      tTgt_q <= tTgt_d; tRel_q <= tRel_d; tBlend_q <= tBlend_d;
      tProf_q <= tProf_d; tEnd_q <= tEnd_d;
      start_q <= start_d; abort_q <= abort_d; home_q <= home_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // children
  dmdc_ramp #(.W(16)) u_ramp (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .target  (rampTarget),
    .step    (step_q),
    .hold    (rampHold),
    .rampOut (rampOut)
  );

  dmdc_diag_enc u_diag (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raise   (raise_q),
    .mainIdx (fltMain_q),
    .subIdx  (fltSub_q),
    .alarm   (diagAlarm),
    .chanErr (chanErrType),
    .extErr  (extChanErrType)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign taskStart = start_q;
  assign taskAbort = abort_q;
  assign taskTarget = tTgt_q;
  assign taskRelative = tRel_q;
  assign taskBlend = tBlend_q;
  assign taskProfVel = tProf_q;
  assign taskEndVel = tEnd_q;
  assign taskAcc = acc_q;
  assign taskDec = dec_q;
  assign homingStart = home_q;
  assign homingMethod = homeMeth_q;
  assign modeActive = modeAct_q;
  assign selFix1 = fix1;
  assign setpointOut = rampOut;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_tel_mode: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    telStb && hwdata[17:16] == 2'h0 |=> modeReq_q == dmdc_pkg::MODE_POS)
    else $error("telegram 0 did not request positioning");
  chk_mode_report: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    modeAct_q != $past(modeAct_q) |-> modeAct_q == $past(modeReq_q)
      && $past(swCnt_q) == SW_LAST)
    else $error("mode changed without settling");
  chk_start_pos: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    start_q && !$past(taskDone) |-> $past(startEdge)
      && $past(modeAct_q) == dmdc_pkg::MODE_POS)
    else $error("task start without rising edge");
  chk_queue_task: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    startEdge && modeAct_q == dmdc_pkg::MODE_POS
      && task_q == dmdc_pkg::TASK_RUN && !newCw[13]
      |=> task_q == dmdc_pkg::TASK_QUEUED && !start_q)
    else $error("task not queued");
  chk_abort_task: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    startEdge && modeAct_q == dmdc_pkg::MODE_POS
      && task_q != dmdc_pkg::TASK_IDLE && newCw[13]
      |=> start_q && abort_q)
    else $error("running task not aborted");
  chk_rel_flag: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    start_q && abort_q |-> tRel_q == $past(newCw[12]))
    else $error("relative flag wrong");
  chk_no_setpt: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    modeAct_q == dmdc_pkg::MODE_SPEED && !cw1_q[6]
      |-> rampTarget == 16'h0000 && !fix1)
    else $error("disabled setpoint still connected");
endmodule // dmdc_top
`default_nettype wire

//--- verif/dmdc_motion_model.sv
// Purpose: motion engine stand-in for the task outputs
// Assumes: one task runs at a time
// Notes:   done pulse after a short or a long delay
`timescale 1ns/10ps
`default_nettype none
module dmdc_motion_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // task handshake
  input  wire logic slow,
  input  wire logic taskStart,
  output logic      taskDone
);
  int cnt;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 0;
      taskDone <= 1'b0;
    end else begin
      taskDone <= (cnt == 1);
      if (taskStart)
        cnt <= slow ? 60 : 3;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule // dmdc_motion_model
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for dmdc_top
// Assumes: zero wait AHB-Lite slave
// Notes:   random fault numbers from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        sys_clk, nrst, hsel, hwrite, hreadyout, hresp, taskDone, slow;
  logic        taskStart, taskAbort, taskRelative, selFix1, diagAlarm;
  logic [7:0]  haddr;
  logic [1:0]  htrans, modeActive;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] chanErrType, extChanErrType;
  logic [7:0]  m;
  logic [3:0]  s;
  logic        taskBlend, homingStart;
  logic [15:0] taskProfVel, taskEndVel, setpointOut;
  int          mismatches, checked, seed;
  dmdc_top dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .taskDone(taskDone), .taskStart(taskStart),
    .taskAbort(taskAbort), .taskTarget(), .taskRelative(taskRelative),
    .taskBlend(taskBlend), .taskProfVel(taskProfVel),
    .taskEndVel(taskEndVel), .taskAcc(), .taskDec(),
    .homingStart(homingStart), .homingMethod(), .modeActive(modeActive),
    .selFix1(selFix1), .setpointOut(setpointOut), .diagAlarm(diagAlarm),
    .chanErrType(chanErrType), .extChanErrType(extChanErrType));
  dmdc_motion_model partner (.sys_clk(sys_clk), .nrst(nrst), .slow(slow),
    .taskStart(taskStart), .taskDone(taskDone));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] tel(logic [1:0] t, logic [15:0] cw);
    return {8'hE0, 5'h0, 1'b1, t, cw};
  endfunction
  function automatic logic [15:0] dcode(logic [7:0] v);
    return 16'h1000 + {8'h00, v};
  endfunction
  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    mismatches++;
    stop_test();
  end
  initial begin
    {nrst, hsel, hwrite, haddr, htrans, hwdata, slow} = '0;
    mismatches = 0;
    checked = 0;
    seed = 32'ha654a44b;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      {m, s} = (i == 0) ? 12'h086 : 12'($random(seed));
      bus(1'b1, 8'h20, {19'h0, 1'b1, s, m});
      @(posedge sys_clk);
      #1;
      chk(diagAlarm, 1'b1);
      chk(chanErrType, dcode(m));
      chk(extChanErrType, dcode({4'h0, s}));
      bus(1'b0, 8'h24, 32'h0);
      chk(rd, {dcode({4'h0, s}), dcode(m)});
    end
    bus(1'b1, 8'h00, tel(2'h1, 16'h0040));
    repeat (260) @(posedge sys_clk);
    #1;
    chk(modeActive, dmdc_pkg::MODE_SPEED);
    chk(selFix1, 1'b1);
    bus(1'b1, 8'h00, tel(2'h1, 16'h0000));
    #1;
    chk(selFix1, 1'b0);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd[1:0], dmdc_pkg::MODE_SPEED);
    bus(1'b1, 8'h00, {8'h5A, 8'h04, 16'h0000});
    repeat (260) @(posedge sys_clk);
    #1;
    chk(modeActive, dmdc_pkg::MODE_SPEED);
    slow <= 1'b1;
    bus(1'b1, 8'h00, tel(2'h0, 16'h0000));
    repeat (260) @(posedge sys_clk);
    #1;
    chk(modeActive, dmdc_pkg::MODE_POS);
    bus(1'b1, 8'h00, tel(2'h0, 16'h1040));
    #1;
    chk({taskStart, taskRelative, taskAbort}, 3'h6);
    bus(1'b1, 8'h00, tel(2'h0, 16'h0040));
    #1;
    chk(taskStart, 1'b0);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd[2:0], 3'h5);
    // abort a running task, homing edge
    bus(1'b1, 8'h10, {16'h0050, 16'h0020});
    bus(1'b1, 8'h00, tel(2'h0, 16'h0800));
    #1;
    chk(homingStart, 1'b1);
    bus(1'b1, 8'h00, tel(2'h0, 16'h2040));
    #1;
    chk({taskStart, taskRelative, taskAbort}, 3'h5);
    bus(1'b1, 8'h10, {16'h0030, 16'h0050});
    bus(1'b1, 8'h00, tel(2'h0, 16'h0000));
    bus(1'b1, 8'h00, tel(2'h0, 16'h0040));
    #1;
    chk(taskStart, 1'b0);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd[1:0], 2'h3);
    do begin
      @(posedge sys_clk);
      #1;
    end while (taskStart !== 1'b1);
    chk(taskBlend, 1'b1);
    chk({taskProfVel, taskEndVel}, 32'h00500030);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, tel(2'h2, 16'h0000));
    repeat (260) @(posedge sys_clk);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd[1:0], dmdc_pkg::MODE_TORQUE);
    bus(1'b1, 8'h08, {16'h0010, 16'h0100});
    repeat (3) @(posedge sys_clk);
    #1;
    chk(setpointOut, 16'h0030);
    bus(1'b0, 8'h3C, 32'h0);
    chk({hresp, hreadyout}, 2'h1);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
